// ### dv/testbench.sv
/* Bench for the trigger select block over APB.
   Assumes tsel_ext_equip on the pins and a short reset interval. */
`timescale 1ns/1ns
`include "tsel_map.svh"
`default_nettype none
module testbench
	import tsel_pkg::*;
;
	logic        clock, nrst, psel, penable, pwrite, pready, pslverr, trig_pulse;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	tsel_cand_s  cand;
	logic        armed, drv_a, drv_b, pin_a, pin_b, out_a, oe_a, out_b, oe_b;
	int          err_total, n_checks, c;
	int          codes[6] = '{1, 4, 5, 6, 8, 9};
	int          bits[6] = '{5, 4, 3, 2, 1, 0};
	int          na[5] = '{12'h104, 12'h204, 12'h106, 12'h206, 12'h105};
	int          nb[5] = '{4, 4, 2, 2, 3};
	// Short reset interval keeps the time trigger run brief
	tsel_trigger #(.IVAL_RST(38'h28)) tsel_trigger_i (.clock(clock), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cand_in(cand),
		.armed_in(armed), .trig_pulse(trig_pulse), .port_a_in(pin_a), .port_a_out(out_a),
		.port_a_oe_n(oe_a), .port_b_in(pin_b), .port_b_out(out_b), .port_b_oe_n(oe_b));
	tsel_ext_equip tsel_ext_equip_i (.drv_a(drv_a), .drv_b(drv_b), .dev_a(out_a),
		.dev_a_oe_n(oe_a), .dev_b(out_b), .dev_b_oe_n(oe_b), .pin_a(pin_a), .pin_b(pin_b));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		if (err_total == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
		xfer(1'b0, a, 32'h0);
		chk("prdata", e, prdata);
		chk("pslverr", ee, pslverr);
	endtask
	task automatic cnt(input int n, input int s);
		c = 0;
		repeat (n) begin
			@(posedge clock);
			#1;
			if ((s == 0 ? trig_pulse : s == 1 ? pin_a : pin_b) === 1'b1) c++;
		end
	endtask
	task automatic edg(input int b, input logic v, input int e, input int s = 0);
		@(posedge clock);
		cand[b] <= v;
		cnt(8, s);
		chk("edge count", e, c);
	endtask
	task automatic pdrv(input logic v, input int e);
		@(posedge clock);
		drv_a <= v;
		cnt(8, 0);
		chk("pin trigger", e, c);
	endtask
	initial begin
		err_total = 0;
		n_checks = 0;
		{nrst, psel, penable, pwrite, armed, drv_a, drv_b} = '0;
		paddr = '0;
		pwdata = '0;
		cand = '0;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		rd(`TSEL_CTRL_OFS, 32'h0, 1'b0);
		rd(`TSEL_INTERVAL_OFS, 32'h28, 1'b0);
		rd(`TSEL_PORT_A_OFS, 32'h0, 1'b0);
		rd(`TSEL_PORT_B_OFS, 32'h0, 1'b0);
		rd(`TSEL_PULSE_LEN_OFS, `TSEL_PULSE_RST, 1'b0);
		rd(12'h01c, 32'h0, 1'b1);
		chk("oe_n", 2'b11, {oe_a, oe_b});
		edg(5, 1'b1, 0);
		edg(5, 1'b0, 0);
		for (int i = 0; i < 6; i++) begin
			wr(`TSEL_CTRL_OFS, 32'(codes[i]));
			edg(bits[i], 1'b1, 1);
			edg(bits[i], 1'b0, 0);
			wr(`TSEL_CTRL_OFS, 32'(codes[i]) | 32'h10);
			edg(bits[i], 1'b1, 0);
			edg(bits[i], 1'b0, 1);
		end
		for (int i = 0; i < 5; i++) begin
			wr(`TSEL_CTRL_OFS, 32'(na[i]));
			edg(nb[i], 1'b1, 0);
			edg(nb[i], 1'b0, 0);
		end
		wr(`TSEL_CTRL_OFS, 32'h205);
		edg(1, 1'b1, 1);
		edg(1, 1'b0, 0);
		wr(`TSEL_CTRL_OFS, 32'h2);
		pdrv(1'b1, 1);
		pdrv(1'b0, 0);
		// Port driven high as output: its own rising pin must not trigger
		wr(`TSEL_PORT_A_OFS, 32'hd);
		pdrv(1'b1, 0);
		pdrv(1'b0, 0);
		rd(`TSEL_STATUS_OFS, 32'h2, 1'b0);
		wr(`TSEL_CTRL_OFS, 32'h17);
		cnt(400, 0);
		chk("time pulses", 10, c);
		wr(`TSEL_CTRL_OFS, 32'h0);
		wr(`TSEL_INTERVAL_OFS, 32'ha);
		rd(`TSEL_INTERVAL_OFS, 32'hc350, 1'b0);
		wr(`TSEL_PORT_A_OFS, 32'h1);
		wr(`TSEL_CTRL_OFS, 32'h1);
		edg(5, 1'b1, 1, 1);
		edg(5, 1'b0, 0, 1);
		wr(`TSEL_PORT_A_OFS, 32'h3);
		@(posedge clock);
		armed <= 1'b1;
		#1 chk("armed lag", 1'b0, pin_a);
		@(posedge clock);
		#1 chk("armed out", 1'b1, pin_a);
		wr(`TSEL_PORT_A_OFS, 32'hd);
		cnt(3, 1);
		chk("user high", 3, c);
		wr(`TSEL_PORT_A_OFS, 32'h9);
		cnt(3, 1);
		chk("level unused", 0, c);
		wr(`TSEL_PORT_B_OFS, 32'h5);
		wr(`TSEL_PULSE_LEN_OFS, 32'h5);
		wr(`TSEL_PULSE_CMD_OFS, 32'h2);
		cnt(10, 2);
		chk("pulse len", 5, c);
		wr(`TSEL_CTRL_OFS, 32'h0);
		edg(5, 1'b1, 0);
		wr(`TSEL_CTRL_OFS, 32'h1);
		cnt(8, 0);
		chk("switch", 0, c);
		// Old source high, new one low: stale history would look like a fall
		wr(`TSEL_CTRL_OFS, 32'h18);
		cnt(8, 0);
		chk("switch", 0, c);
		edg(1, 1'b1, 0);
		edg(1, 1'b0, 1);
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clock);
		err_total++;
		stop_test();
	end
endmodule
`default_nettype wire

// ### dv/tsel_ext_equip.sv
/* External trigger equipment on the two bidirectional pins.
   Assumes active low pin enables on the device side. */
`timescale 1ns/1ns
`default_nettype none
module tsel_ext_equip (
	// Levels the equipment sends
	input  wire logic drv_a,
	input  wire logic drv_b,
	// Device side of the pins
	input  wire logic dev_a,
	input  wire logic dev_a_oe_n,
	input  wire logic dev_b,
	input  wire logic dev_b_oe_n,
	// Resolved pin levels
	output logic      pin_a,
	output logic      pin_b
);
	// Backs off while the device drives, so no contention
	assign pin_a = dev_a_oe_n ? drv_a : dev_a;
	assign pin_b = dev_b_oe_n ? drv_b : dev_b;
endmodule
`default_nettype wire

// ### dv/tsel_monitor.sv
/* Assertion checker for the trigger select block ports.
   Assumes it is bound to tsel_trigger and shadows APB writes itself. */
`timescale 1ns/1ns
`include "tsel_map.svh"
`default_nettype none
module tsel_monitor (
	// System and APB
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Trigger side
	input wire logic        armed_in,
	input wire logic        trig_pulse,
	input wire logic        port_a_out,
	input wire logic        port_a_oe_n,
	input wire logic        port_b_oe_n
);
	// ----------------
	// Shadow settings
	// ----------------
	logic [9:0] ctrl_reg, ctrl_next;
	logic [3:0] pa_reg, pa_next, pb_reg, pb_next;
	logic       wr;
	assign wr = psel && penable && pwrite && pready;
	always_comb begin
		ctrl_next = (wr && paddr == `TSEL_CTRL_OFS) ? pwdata[9:0] : ctrl_reg;
		pa_next = (wr && paddr == `TSEL_PORT_A_OFS) ? pwdata[3:0] : pa_reg;
		pb_next = (wr && paddr == `TSEL_PORT_B_OFS) ? pwdata[3:0] : pb_reg;
	end
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= '0;
			pa_reg <= '0;
			pb_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			pa_reg <= pa_next;
			pb_reg <= pb_next;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	chk_oe_reset: assert property ($rose(nrst) |-> port_a_oe_n && port_b_oe_n)
		else $error("pins not input after reset");
	chk_oe_dir: assert property (port_a_oe_n == !pa_reg[0] && port_b_oe_n == !pb_reg[0])
		else $error("pin enable differs from direction");
	chk_trig_single: assert property (trig_pulse |=> !trig_pulse)
		else $error("trigger pulse too long");
	chk_free_quiet: assert property ($stable(ctrl_reg) && ctrl_reg[3:0] == 4'h0 |-> !trig_pulse)
		else $error("trigger in free run");
	// The two cycles after the write cycle may not trigger
	chk_switch_quiet: assert property (wr && paddr == `TSEL_CTRL_OFS &&
		pwdata[9:0] != ctrl_reg |=> !trig_pulse [*2])
		else $error("false trigger after switch");
	chk_dev_mirror: assert property (pa_reg == 4'h1 && $stable(pa_reg) |-> port_a_out == trig_pulse)
		else $error("device mode pin differs");
	chk_armed_lag: assert property (pa_reg == 4'h3 && $stable(pa_reg) |-> port_a_out == $past(armed_in))
		else $error("armed pin wrong");
	chk_user_high: assert property (pa_reg == 4'hd |=> port_a_out)
		else $error("user level not driven");
	cov_trig: cover property (trig_pulse);
	cov_armed: cover property (pa_reg == 4'h3 && port_a_out);
	cov_switch: cover property (wr && paddr == `TSEL_CTRL_OFS);
endmodule
bind tsel_trigger tsel_monitor tsel_monitor_i (.clock(clock), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
	.armed_in(armed_in), .trig_pulse(trig_pulse), .port_a_out(port_a_out),
	.port_a_oe_n(port_a_oe_n), .port_b_oe_n(port_b_oe_n));
`default_nettype wire

// ### include/tsel_map.svh
/*
 * Offsets, field positions, reset values and timing counts of the trigger select block.
 * Assumes a 25 MHz system clock and an APB slave with 32-bit data.
 */
`ifndef TSEL_MAP_SVH
`define TSEL_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TSEL_CTRL_OFS       12'h000
`define TSEL_INTERVAL_OFS   12'h004
`define TSEL_PORT_A_OFS     12'h008
`define TSEL_PORT_B_OFS     12'h00c
`define TSEL_PULSE_LEN_OFS  12'h010
`define TSEL_PULSE_CMD_OFS  12'h014
`define TSEL_STATUS_OFS     12'h018

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSEL_CTRL_SRC_LSB   0
`define TSEL_CTRL_SRC_W     4
`define TSEL_CTRL_POL_BIT   4
`define TSEL_CTRL_INP_LSB   8
`define TSEL_PORT_DIR_BIT   0
`define TSEL_PORT_TYPE_LSB  1
`define TSEL_PORT_LVL_BIT   3
`define TSEL_CMD_A_BIT      0
`define TSEL_CMD_B_BIT      1

// ----------------------------------------
// Timing
// ----------------------------------------
`define TSEL_CLK_HZ         25000000
`define TSEL_IVAL_MIN_US    2000
`define TSEL_IVAL_MAX_S     5000
`define TSEL_IVAL_RST_MS    1000
`define TSEL_CYC_PER_US     (`TSEL_CLK_HZ / 1000000)
`define TSEL_CYC_PER_MS     (`TSEL_CLK_HZ / 1000)
`define TSEL_IVAL_MIN_CYC   (`TSEL_IVAL_MIN_US * `TSEL_CYC_PER_US)
`define TSEL_IVAL_MAX_CYC   (64'(`TSEL_IVAL_MAX_S) * 64'(`TSEL_CLK_HZ))
`define TSEL_IVAL_RST_CYC   (`TSEL_IVAL_RST_MS * `TSEL_CYC_PER_MS)
`define TSEL_PULSE_RST      32'h0000_0019

`endif

// ### include/tsel_pkg.sv
/*
 * Types of the trigger select block.
 * Assumes tsel_map.svh for numeric constants.
 */
package tsel_pkg;

	typedef enum logic [3:0] {
		free_run_source       = 4'h0,
		ext_port_source       = 4'h1,
		bidir_port_a_source   = 4'h2,
		bidir_port_b_source   = 4'h3,
		rf_power_source       = 4'h4,
		if_power_source       = 4'h5,
		iq_magnitude_source   = 4'h6,
		time_interval_source  = 4'h7,
		baseband_power_source = 4'h8,
		power_sensor_source   = 4'h9
	} tsel_src_e;

	typedef enum logic [1:0] {
		rf_input       = 2'h0,
		digital_bb_input = 2'h1,
		analog_bb_input  = 2'h2
	} tsel_input_e;

	typedef enum logic [1:0] {
		device_out    = 2'h0,
		armed_out     = 2'h1,
		user_level_out = 2'h2
	} tsel_otype_e;

	typedef struct packed {
		logic        dir_out;
		tsel_otype_e otype;
		logic        level;
	} tsel_port_cfg_s;

	typedef struct packed {
		logic ext_port;
		logic rf_power;
		logic if_power;
		logic iq_magnitude;
		logic baseband_power;
		logic power_sensor;
	} tsel_cand_s;

endpackage

// ### verilog/tsel_trigger.sv
/*
 * Trigger source select, edge qualify, time trigger and two bidirectional trigger ports.
 * Assumes an APB master on the same clock; candidate comparator outputs and
 * trigger pins are asynchronous and pass two flip-flops here.
 */
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
`include "tsel_map.svh"
`default_nettype none

module tsel_trigger
	import tsel_pkg::*;
#(
	parameter int unsigned IVAL_W = 38,
	parameter logic [37:0] IVAL_RST = 38'(`TSEL_IVAL_RST_CYC)
) (
	// System
	input  wire logic        clock,
	input  wire logic        nrst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Candidate trigger conditions, asynchronous levels
	input  wire tsel_cand_s  cand_in,
	// Capture engine
	input  wire logic        armed_in,
	output logic             trig_pulse,
	// Bidirectional port A
	input  wire logic        port_a_in,
	output logic             port_a_out,
	output logic             port_a_oe_n,
	// Bidirectional port B
	input  wire logic        port_b_in,
	output logic             port_b_out,
	output logic             port_b_oe_n
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NS = 8;
	logic [NS-1:0] sync1_reg, sync2_reg, sync_d;
	assign sync_d = {port_b_in, port_a_in, cand_in};

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= sync_d;
			sync2_reg <= sync1_reg;
		end
	end

	tsel_cand_s cand_s;
	logic       pin_a_s, pin_b_s;
	assign {pin_b_s, pin_a_s, cand_s} = sync2_reg;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	tsel_src_e        src_reg, src_next;
	logic             pol_falling_reg, pol_falling_next;
	tsel_input_e      inp_reg, inp_next;
	logic [IVAL_W-1:0] ival_reg, ival_next;
	tsel_port_cfg_s   cfg_a_reg, cfg_a_next, cfg_b_reg, cfg_b_next;
	logic [31:0]      plen_reg, plen_next;
	logic             cfg_changed;
	logic             cmd_a, cmd_b;

	logic wr_en, rd_en;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;

	logic addr_ok;
	always_comb begin
		unique case (paddr)
			`TSEL_CTRL_OFS, `TSEL_INTERVAL_OFS, `TSEL_PORT_A_OFS, `TSEL_PORT_B_OFS,
			`TSEL_PULSE_LEN_OFS, `TSEL_PULSE_CMD_OFS, `TSEL_STATUS_OFS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && !addr_ok;

	function automatic tsel_port_cfg_s dec_port(input logic [31:0] d);
		tsel_port_cfg_s c;
		c.dir_out = d[`TSEL_PORT_DIR_BIT];
		c.otype   = tsel_otype_e'(d[`TSEL_PORT_TYPE_LSB +: 2]);
		c.level   = d[`TSEL_PORT_LVL_BIT];
		return c;
	endfunction

	always_comb begin
		src_next         = src_reg;
		pol_falling_next = pol_falling_reg;
		inp_next         = inp_reg;
		ival_next        = ival_reg;
		cfg_a_next       = cfg_a_reg;
		cfg_b_next       = cfg_b_reg;
		plen_next        = plen_reg;
		cmd_a            = 1'b0;
		cmd_b            = 1'b0;
		if (wr_en) begin
			unique case (paddr)
				`TSEL_CTRL_OFS: begin
					// Codes beyond the list fall back to free run
					if (pwdata[`TSEL_CTRL_SRC_LSB +: `TSEL_CTRL_SRC_W] <= 4'h9)
						src_next = tsel_src_e'(pwdata[`TSEL_CTRL_SRC_LSB +: `TSEL_CTRL_SRC_W]);
					else
						src_next = free_run_source;
					pol_falling_next = pwdata[`TSEL_CTRL_POL_BIT];
					inp_next = tsel_input_e'(pwdata[`TSEL_CTRL_INP_LSB +: 2]);
				end
				`TSEL_INTERVAL_OFS: begin
					// Clamp up to the minimum legal interval; no upper limit is applied
					if (64'(pwdata) < 64'(`TSEL_IVAL_MIN_CYC))
						ival_next = IVAL_W'(`TSEL_IVAL_MIN_CYC);
					else
						ival_next = IVAL_W'(pwdata);
				end
				`TSEL_PORT_A_OFS:    cfg_a_next = dec_port(pwdata);
				`TSEL_PORT_B_OFS:    cfg_b_next = dec_port(pwdata);
				`TSEL_PULSE_LEN_OFS: plen_next  = (pwdata == 32'h0) ? 32'h1 : pwdata;
				`TSEL_PULSE_CMD_OFS: begin
					cmd_a = pwdata[`TSEL_CMD_A_BIT];
					cmd_b = pwdata[`TSEL_CMD_B_BIT];
				end
				default: ;
			endcase
		end
	end

	assign cfg_changed = (src_next != src_reg) || (pol_falling_next != pol_falling_reg) ||
		(inp_next != inp_reg) || (cfg_a_next.dir_out != cfg_a_reg.dir_out) ||
		(cfg_b_next.dir_out != cfg_b_reg.dir_out);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			src_reg         <= free_run_source;
			pol_falling_reg <= 1'b0;
			inp_reg         <= rf_input;
			ival_reg        <= IVAL_W'(IVAL_RST);
			cfg_a_reg       <= '{dir_out: 1'b0, otype: device_out, level: 1'b0};
			cfg_b_reg       <= '{dir_out: 1'b0, otype: device_out, level: 1'b0};
			plen_reg        <= `TSEL_PULSE_RST;
		end else begin
			src_reg         <= src_next;
			pol_falling_reg <= pol_falling_next;
			inp_reg         <= inp_next;
			ival_reg        <= ival_next;
			cfg_a_reg       <= cfg_a_next;
			cfg_b_reg       <= cfg_b_next;
			plen_reg        <= plen_next;
		end
	end

	// ----------------------------------------
	// Source select and edge qualify
	// ----------------------------------------
	logic raw_level, src_avail;
	logic is_bb;
	assign is_bb = (inp_reg != rf_input);

	always_comb begin
		raw_level = 1'b0;
		src_avail = 1'b1;
		unique case (src_reg)
			free_run_source:       raw_level = 1'b0;
			ext_port_source:       raw_level = cand_s.ext_port;
			// Port only counts as a source while set to input
			bidir_port_a_source: begin
				raw_level = pin_a_s;
				src_avail = !cfg_a_reg.dir_out;
			end
			bidir_port_b_source: begin
				raw_level = pin_b_s;
				src_avail = !cfg_b_reg.dir_out;
			end
			rf_power_source: begin
				raw_level = cand_s.rf_power;
				src_avail = !is_bb;
			end
			if_power_source: begin
				// Analog baseband reinterprets as baseband power
				raw_level = (inp_reg == analog_bb_input) ? cand_s.baseband_power
				                                          : cand_s.if_power;
				src_avail = (inp_reg != digital_bb_input);
			end
			iq_magnitude_source: begin
				raw_level = cand_s.iq_magnitude;
				src_avail = !is_bb;
			end
			time_interval_source:  raw_level = 1'b0;
			baseband_power_source: raw_level = cand_s.baseband_power;
			power_sensor_source:   raw_level = cand_s.power_sensor;
			default:               src_avail = 1'b0;
		endcase
	end

	// Edge history restarts after a switch so stale level is not an edge
	logic prev_reg, prev_next, hist_ok_reg, hist_ok_next;
	always_comb begin
		prev_next    = raw_level;
		hist_ok_next = !cfg_changed;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prev_reg    <= 1'b0;
			hist_ok_reg <= 1'b0;
		end else begin
			prev_reg    <= prev_next;
			hist_ok_reg <= hist_ok_next;
		end
	end

	logic edge_hit;
	assign edge_hit = hist_ok_reg && src_avail && !cfg_changed &&
		(pol_falling_reg ? (prev_reg && !raw_level) : (!prev_reg && raw_level));

	// ----------------------------------------
	// Time trigger
	// ----------------------------------------
	logic [IVAL_W-1:0] tcnt_reg, tcnt_next;
	logic              time_hit;
	always_comb begin
		time_hit  = 1'b0;
		tcnt_next = '0;
		if (src_reg == time_interval_source && !cfg_changed) begin
			if (tcnt_reg >= ival_reg - IVAL_W'(1)) begin
				time_hit  = 1'b1;
				tcnt_next = '0;
			end else begin
				tcnt_next = tcnt_reg + IVAL_W'(1);
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			tcnt_reg <= '0;
		else
			tcnt_reg <= tcnt_next;
	end

	// ----------------------------------------
	// Trigger pulse and port outputs
	// ----------------------------------------
	logic        trig_next;
	logic [31:0] pcnt_a_reg, pcnt_a_next, pcnt_b_reg, pcnt_b_next;
	logic        out_a_next, out_b_next;

	assign trig_next = (src_reg == time_interval_source) ? time_hit : edge_hit;

	function automatic logic port_val(input tsel_port_cfg_s c, input logic trg, input logic arm,
	                                  input logic pulse);
		logic v;
		unique case (c.otype)
			device_out:     v = trg;
			armed_out:      v = arm;
			user_level_out: v = c.level;
			default:        v = 1'b0;
		endcase
		return v | pulse;
	endfunction

	always_comb begin
		pcnt_a_next = (pcnt_a_reg != 32'h0) ? pcnt_a_reg - 32'h1 : 32'h0;
		pcnt_b_next = (pcnt_b_reg != 32'h0) ? pcnt_b_reg - 32'h1 : 32'h0;
		if (cmd_a)
			pcnt_a_next = plen_reg;
		if (cmd_b)
			pcnt_b_next = plen_reg;
		out_a_next = port_val(cfg_a_reg, trig_next, armed_in, pcnt_a_reg != 32'h0);
		out_b_next = port_val(cfg_b_reg, trig_next, armed_in, pcnt_b_reg != 32'h0);
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			trig_pulse <= 1'b0;
			pcnt_a_reg <= '0;
			pcnt_b_reg <= '0;
			port_a_out <= 1'b0;
			port_b_out <= 1'b0;
		end else begin
			trig_pulse <= trig_next;
			pcnt_a_reg <= pcnt_a_next;
			pcnt_b_reg <= pcnt_b_next;
			port_a_out <= out_a_next;
			port_b_out <= out_b_next;
		end
	end

	assign port_a_oe_n = !cfg_a_reg.dir_out;
	assign port_b_oe_n = !cfg_b_reg.dir_out;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_comb begin
		prdata = 32'h0;
		if (rd_en) begin
			unique case (paddr)
				`TSEL_CTRL_OFS: prdata = {22'h0, inp_reg, 3'h0, pol_falling_reg, src_reg};
				`TSEL_INTERVAL_OFS: prdata = 32'(ival_reg);
				`TSEL_PORT_A_OFS: prdata = {28'h0, cfg_a_reg.level, cfg_a_reg.otype,
				                            cfg_a_reg.dir_out};
				`TSEL_PORT_B_OFS: prdata = {28'h0, cfg_b_reg.level, cfg_b_reg.otype,
				                            cfg_b_reg.dir_out};
				`TSEL_PULSE_LEN_OFS: prdata = plen_reg;
				`TSEL_STATUS_OFS: prdata = {27'h0, pcnt_b_reg != 32'h0, pcnt_a_reg != 32'h0,
				                            pin_b_s, pin_a_s, src_avail};
				default: prdata = 32'h0;
			endcase
		end
	end

endmodule

`default_nettype wire
